// ---- rtl/usm_pkg.sv ----
package usm_pkg;

  // register byte addresses
  localparam logic [31:0] OFF_DATA      = 32'hffff0700;
  localparam logic [31:0] OFF_IRQ_EN    = 32'hffff0704;
  localparam logic [31:0] OFF_IRQ_ID    = 32'hffff0708;
  localparam logic [31:0] OFF_LINE_FMT  = 32'hffff070c;
  localparam logic [31:0] OFF_MODEM_CTL = 32'hffff0710;
  localparam logic [31:0] OFF_LINE_STS  = 32'hffff0714;
  localparam logic [31:0] OFF_MODEM_STS = 32'hffff0718;

  // values after reset
  localparam logic [7:0] RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_IRQ_ID    = 8'h01;
  localparam logic [7:0] RST_MODEM_CTL = 8'h00;
  localparam logic [7:0] RST_LINE_STS  = 8'h60;
  localparam logic [7:0] RST_MODEM_STS = 8'h00;
  localparam logic [7:0] RST_LINE_FMT  = 8'h00;
  localparam logic [7:0] RST_DATA      = 8'h00;

  // writable bits
  localparam logic [7:0] MASK_IRQ_EN    = 8'h0f;
  localparam logic [7:0] MASK_MODEM_CTL = 8'h13;

  // field positions
  localparam int DIVISOR_ACCESS_SEL = 7;
  localparam int LOOPBACK_BIT       = 4;
  localparam int RTS_BIT            = 1;
  localparam int DTR_BIT            = 0;
  localparam int MODEM_IRQ_EN       = 3;
  localparam int LINE_STATUS_IRQ_EN = 2;
  localparam int TX_EMPTY_IRQ_EN    = 1;
  localparam int RX_FULL_IRQ_EN     = 0;
  localparam int CLEAR_SEND_BIT     = 4;
  localparam int CLEAR_SEND_CHANGED = 0;
  localparam int TX_ALL_EMPTY       = 6;
  localparam int TX_HOLDING_EMPTY   = 5;
  localparam int BREAK_SEEN         = 4;
  localparam int FRAMING_ERR        = 3;
  localparam int PARITY_ERR         = 2;
  localparam int OVERRUN_ERR        = 1;
  localparam int RX_DATA_READY      = 0;

  // identification codes, bits 2:0
  localparam logic [2:0] ID_NONE    = 3'b001;
  localparam logic [2:0] ID_LINE    = 3'b110;
  localparam logic [2:0] ID_RX_FULL = 3'b100;
  localparam logic [2:0] ID_TX_EMPT = 3'b010;
  localparam logic [2:0] ID_MODEM   = 3'b000;

endpackage

// ---- rtl/usm_status_irq.sv ----
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module usm_status_irq (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_serial,
  input  wire logic        tx_shift_empty,
  input  wire logic        tx_load,
  output logic             tx_pin,
  output logic      [7:0]  tx_data,
  output logic             tx_data_valid,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_parity_bad,
  input  wire logic        rx_frame_bad,
  input  wire logic        rx_break,
  input  wire logic        cts_n,
  output logic             rts_n,
  output logic             dtr_n,
  output logic             loopback,
  output logic      [7:0]  line_format,
  output logic             irq
);

  logic [7:0] irq_en;
  logic [7:0] modem_ctl;
  logic [7:0] line_fmt;
  logic [7:0] rx_buf;
  logic       hold_full;
  logic       rx_data_ready;
  logic       overrun_err;
  logic       parity_err;
  logic       framing_err;
  logic       break_seen;
  logic       clear_send;
  logic       clear_send_changed;
  logic       tx_empty_pend;
  logic       tx_all_empty;
  logic       tx_holding_empty;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [2:0] irq_code;
  logic       line_pend;
  logic       rx_pend;
  logic       tx_pend;
  logic       modem_pend;
  logic       setup_ph;
  logic       wr_acc;
  logic       rd_acc;
  logic       divisor_access_sel;
  logic       sel_data;
  logic       sel_ien;
  logic       sel_iid;
  logic       sel_fmt;
  logic       sel_mctl;
  logic       sel_lsts;
  logic       sel_msts;
  logic       sel_div;
  logic       mapped;
  logic [7:0] next_rdata;
  logic       hold_wr;
  logic       rx_rd;
  logic       lsts_rd;
  logic       msts_rd;
  logic       iid_rd;

  // zero wait states: read data is caught in the setup cycle
  assign pready   = 1'b1;
  assign setup_ph = psel & ~penable;
  assign wr_acc   = pce & psel & penable & pwrite;
  assign rd_acc   = pce & psel & penable & ~pwrite;

  assign divisor_access_sel     = line_fmt[usm_pkg::DIVISOR_ACCESS_SEL];
  assign sel_data = (paddr == usm_pkg::OFF_DATA) & ~divisor_access_sel;
  assign sel_ien  = (paddr == usm_pkg::OFF_IRQ_EN) & ~divisor_access_sel;
  assign sel_div  = ((paddr == usm_pkg::OFF_DATA) | (paddr == usm_pkg::OFF_IRQ_EN)) & divisor_access_sel;
  assign sel_iid  = paddr == usm_pkg::OFF_IRQ_ID;
  assign sel_fmt  = paddr == usm_pkg::OFF_LINE_FMT;
  assign sel_mctl = paddr == usm_pkg::OFF_MODEM_CTL;
  assign sel_lsts = paddr == usm_pkg::OFF_LINE_STS;
  assign sel_msts = paddr == usm_pkg::OFF_MODEM_STS;
  assign mapped   = sel_data | sel_ien | sel_div | sel_iid | sel_fmt | sel_mctl
                  | sel_lsts | sel_msts;

  assign hold_wr = wr_acc & sel_data;
  assign rx_rd   = rd_acc & sel_data;
  assign lsts_rd = rd_acc & sel_lsts;
  assign msts_rd = rd_acc & sel_msts;
  assign iid_rd  = rd_acc & sel_iid;

  assign tx_holding_empty = ~hold_full;
  assign tx_all_empty     = ~hold_full & tx_shift_empty;
  assign line_status = {1'b0, tx_all_empty, tx_holding_empty, break_seen,
                        framing_err, parity_err, overrun_err, rx_data_ready};
  assign modem_status = {3'b000, clear_send, 3'b000, clear_send_changed};

  assign line_pend  = irq_en[usm_pkg::LINE_STATUS_IRQ_EN]
                    & (overrun_err | parity_err | framing_err);
  assign rx_pend    = irq_en[usm_pkg::RX_FULL_IRQ_EN] & rx_data_ready;
  assign tx_pend    = irq_en[usm_pkg::TX_EMPTY_IRQ_EN] & tx_empty_pend;
  assign modem_pend = irq_en[usm_pkg::MODEM_IRQ_EN]
                    & (clear_send | clear_send_changed);

  always_comb begin
    if (line_pend) begin
      irq_code = usm_pkg::ID_LINE;
    end else if (rx_pend) begin
      irq_code = usm_pkg::ID_RX_FULL;
    end else if (tx_pend) begin
      irq_code = usm_pkg::ID_TX_EMPT;
    end else if (modem_pend) begin
      irq_code = usm_pkg::ID_MODEM;
    end else begin
      irq_code = usm_pkg::ID_NONE;
    end
  end

  // divisor bytes live elsewhere and read as zero here
  always_comb begin
    next_rdata = 8'h00;
    if (sel_data) begin
      next_rdata = rx_buf;
    end else if (sel_ien) begin
      next_rdata = irq_en;
    end else if (sel_iid) begin
      next_rdata = {5'b00000, irq_code};
    end else if (sel_fmt) begin
      next_rdata = line_fmt;
    end else if (sel_mctl) begin
      next_rdata = modem_ctl;
    end else if (sel_lsts) begin
      next_rdata = line_status;
    end else if (sel_msts) begin
      next_rdata = modem_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (pce && setup_ph) begin
      prdata  <= {24'h000000, next_rdata};
      pslverr <= ~mapped;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en    <= usm_pkg::RST_IRQ_EN;
      modem_ctl <= usm_pkg::RST_MODEM_CTL;
      line_fmt  <= usm_pkg::RST_LINE_FMT;
    end else if (wr_acc) begin
      if (sel_ien) begin
        irq_en <= pwdata[7:0] & usm_pkg::MASK_IRQ_EN;
      end
      if (sel_mctl) begin
        modem_ctl <= pwdata[7:0] & usm_pkg::MASK_MODEM_CTL;
      end
      if (sel_fmt) begin
        line_fmt <= pwdata[7:0];
      end
    end
  end

  assign rts_n       = ~modem_ctl[usm_pkg::RTS_BIT];
  assign dtr_n       = ~modem_ctl[usm_pkg::DTR_BIT];
  assign loopback    = modem_ctl[usm_pkg::LOOPBACK_BIT];
  assign line_format = line_fmt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin <= 1'b1;
    end else if (pce) begin
      tx_pin <= modem_ctl[usm_pkg::LOOPBACK_BIT] | tx_serial;
    end
  end

  // transmit holding register; a write in the load cycle keeps it full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data   <= usm_pkg::RST_DATA;
      hold_full <= 1'b0;
    end else if (pce) begin
      if (hold_wr) begin
        tx_data   <= pwdata[7:0];
        hold_full <= 1'b1;
      end else if (tx_load) begin
        hold_full <= 1'b0;
      end
    end
  end

  assign tx_data_valid = hold_full;

  // transmit-empty source: armed when holding empties or its enable rises while holding is empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_pend <= 1'b0;
    end else if (pce) begin
      if (hold_full && tx_load && !hold_wr) begin
        tx_empty_pend <= 1'b1;
      end else if (wr_acc && sel_ien && pwdata[usm_pkg::TX_EMPTY_IRQ_EN]
                   && !irq_en[usm_pkg::TX_EMPTY_IRQ_EN] && !hold_full) begin
        tx_empty_pend <= 1'b1;
      end else if (hold_wr || (iid_rd && prdata[2:0] == usm_pkg::ID_TX_EMPT)) begin
        tx_empty_pend <= 1'b0;
      end
    end
  end

  // receive side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf        <= usm_pkg::RST_DATA;
      rx_data_ready <= 1'b0;
      overrun_err   <= 1'b0;
    end else if (pce) begin
      if (rx_char_valid) begin
        rx_buf        <= rx_char_data;
        rx_data_ready <= 1'b1;
      end else if (rx_rd) begin
        rx_data_ready <= 1'b0;
      end
      if (rx_char_valid && rx_data_ready && !rx_rd) begin
        overrun_err <= 1'b1;
      end else if (lsts_rd && prdata[usm_pkg::OVERRUN_ERR]) begin
        overrun_err <= 1'b0;
      end
    end
  end

  // error flags: cleared only if the read actually returned them set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_err  <= 1'b0;
      framing_err <= 1'b0;
      break_seen  <= 1'b0;
    end else if (pce) begin
      if (rx_char_valid && rx_parity_bad) begin
        parity_err <= 1'b1;
      end else if (lsts_rd && prdata[usm_pkg::PARITY_ERR]) begin
        parity_err <= 1'b0;
      end
      if (rx_char_valid && rx_frame_bad) begin
        framing_err <= 1'b1;
      end else if (lsts_rd && prdata[usm_pkg::FRAMING_ERR]) begin
        framing_err <= 1'b0;
      end
      if (rx_break) begin
        break_seen <= 1'b1;
      end else if (lsts_rd && prdata[usm_pkg::BREAK_SEEN]) begin
        break_seen <= 1'b0;
      end
    end
  end

  // modem status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_send         <= 1'b0;
      clear_send_changed <= 1'b0;
    end else if (pce) begin
      clear_send <= ~cts_n;
      if (clear_send != ~cts_n) begin
        clear_send_changed <= 1'b1;
      end else if (msts_rd && prdata[usm_pkg::CLEAR_SEND_CHANGED]) begin
        clear_send_changed <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (pce) begin
      irq <= line_pend | rx_pend | tx_pend | modem_pend;
    end
  end

  a_loop_tx_high: assert property (@(posedge pclk) disable iff (!presetn)
    pce && loopback |=> tx_pin)
    else $error("transmit pin low in loopback");

  a_rts_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && sel_mctl |=> rts_n == !$past(pwdata[1]))
    else $error("request-to-send does not follow control write");

  a_dtr_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && sel_mctl |=> dtr_n == !$past(pwdata[0]))
    else $error("terminal-ready does not follow control write");

  a_lsts_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) && tx_shift_empty |-> line_status == usm_pkg::RST_LINE_STS)
    else $error("line status wrong after reset");

  a_tx_all_empty_clear: assert property (@(posedge pclk) disable iff (!presetn)
    hold_wr |=> !line_status[6])
    else $error("all-empty flag survives holding write");

  a_tx_holding_empty_clear: assert property (@(posedge pclk) disable iff (!presetn)
    hold_wr |=> !line_status[5] && tx_data_valid)
    else $error("holding-empty flag survives holding write");

  a_ready_set: assert property (@(posedge pclk) disable iff (!presetn)
    pce && rx_char_valid |=> line_status[0] && rx_buf == $past(rx_char_data))
    else $error("data ready not set by new character");

  a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    pce && rx_char_valid && rx_data_ready && !rx_rd |=> overrun_err)
    else $error("overrun not flagged");

  a_cts_delta: assert property (@(posedge pclk) disable iff (!presetn)
    pce && (clear_send == cts_n) |=> clear_send_changed)
    else $error("clear-to-send change not flagged");

  a_id_line_first: assert property (@(posedge pclk) disable iff (!presetn)
    line_pend && setup_ph && pce && sel_iid |=> prdata[2:0] == 3'b110)
    else $error("line status not reported first");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    pce && (irq_code != usm_pkg::ID_NONE) |=> irq)
    else $error("interrupt output low while source pends");

  a_break_set: assert property (@(posedge pclk) disable iff (!presetn)
    pce && rx_break |=> line_status[4])
    else $error("break not flagged");

  a_frame_set: assert property (@(posedge pclk) disable iff (!presetn)
    pce && rx_char_valid && rx_frame_bad |=> line_status[3])
    else $error("framing error not flagged");

  a_parity_set: assert property (@(posedge pclk) disable iff (!presetn)
    pce && rx_char_valid && rx_parity_bad |=> line_status[2])
    else $error("parity error not flagged");

  a_cts_level: assert property (@(posedge pclk) disable iff (!presetn)
    pce |=> modem_status[4] == !$past(cts_n))
    else $error("clear-to-send level not shown");

  // clock enable low must hold every register
  a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !pce |=> $stable(hold_full) && $stable(irq) && $stable(prdata) && $stable(line_status))
    else $error("state changed while clock enable low");

endmodule

// ---- dv/usm_peer.sv ----
`timescale 1ns/1ps
module usm_peer (
  input  wire logic       pclk,
  output logic            tx_serial,
  output logic            tx_shift_empty,
  output logic            tx_load,
  output logic            rx_char_valid,
  output logic      [7:0] rx_char_data,
  output logic            rx_parity_bad,
  output logic            rx_frame_bad,
  output logic            rx_break,
  output logic            cts_n
);
  initial begin
    tx_serial      = 1'b0;
    tx_shift_empty = 1'b1;
    tx_load        = 1'b0;
    rx_char_valid  = 1'b0;
    rx_char_data   = 8'h00;
    rx_parity_bad  = 1'b0;
    rx_frame_bad   = 1'b0;
    rx_break       = 1'b0;
    cts_n          = 1'b1;
  end
  // qualifiers are meaningless once valid falls, so they flip
  task automatic rx(input logic [7:0] d, input logic pe, input logic fe, input logic brk);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data  <= d;
    rx_parity_bad <= pe;
    rx_frame_bad  <= fe;
    rx_break      <= brk;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data  <= ~d;
    rx_parity_bad <= ~pe;
    rx_frame_bad  <= ~fe;
    rx_break      <= 1'b0;
  endtask
  task automatic shift(input logic empty, input logic load);
    @(posedge pclk);
    tx_load        <= load;
    tx_shift_empty <= empty;
    @(posedge pclk);
    tx_load        <= 1'b0;
  endtask
  // line is held a few cycles so the sampler sees it
  task automatic cts(input logic v);
    @(posedge pclk);
    cts_n <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ---- dv/usm_status_irq_tb.sv ----
`timescale 1ns/1ps
module usm_status_irq_tb;
  logic        pclk;
  logic        presetn;
  logic        pce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_serial;
  logic        tx_shift_empty;
  logic        tx_load;
  logic        tx_pin;
  logic [7:0]  tx_data;
  logic        tx_data_valid;
  logic        rx_char_valid;
  logic [7:0]  rx_char_data;
  logic        rx_parity_bad;
  logic        rx_frame_bad;
  logic        rx_break;
  logic        cts_n;
  logic        rts_n;
  logic        dtr_n;
  logic        loopback;
  logic [7:0]  line_format;
  logic        irq;
  int          n_fail;
  int          tests_run;
  logic [31:0] d;
  logic        e;

  usm_status_irq usm_status_irq_inst (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_serial(tx_serial),
    .tx_shift_empty(tx_shift_empty), .tx_load(tx_load), .tx_pin(tx_pin), .tx_data(tx_data),
    .tx_data_valid(tx_data_valid), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_parity_bad(rx_parity_bad), .rx_frame_bad(rx_frame_bad),
    .rx_break(rx_break), .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n), .loopback(loopback),
    .line_format(line_format), .irq(irq));

  usm_peer usm_peer_inst (.pclk(pclk), .tx_serial(tx_serial), .tx_shift_empty(tx_shift_empty),
    .tx_load(tx_load), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_parity_bad(rx_parity_bad), .rx_frame_bad(rx_frame_bad), .rx_break(rx_break),
    .cts_n(cts_n));

  always #5 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic        er;
    apb(1'b0, a, 32'h0, v, er);
    chk(v, exp);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic        er;
    apb(1'b1, a, v, r, er);
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (irq === exp) break;
    end
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // pins as {loopback, rts_n, dtr_n, tx_pin}
  task automatic pins(input logic [3:0] exp);
    @(posedge pclk);
    #1;
    chk({28'h0, loopback, rts_n, dtr_n, tx_pin}, {28'h0, exp});
  endtask

  initial begin
    #200us;
    n_fail++;
    end_sim();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(usm_pkg::OFF_LINE_STS, 32'h60);
    rd(usm_pkg::OFF_IRQ_ID, 32'h01);
    rd(usm_pkg::OFF_IRQ_EN, 32'h00);
    rd(usm_pkg::OFF_MODEM_CTL, 32'h00);
    rd(usm_pkg::OFF_MODEM_STS, 32'h00);
    pins(4'h6);
    $display("test reset done");
    wr(usm_pkg::OFF_MODEM_CTL, 32'hff);
    rd(usm_pkg::OFF_MODEM_CTL, 32'h13);
    pins(4'h9);
    wr(usm_pkg::OFF_MODEM_CTL, 32'h02);
    pins(4'h2);
    wr(usm_pkg::OFF_MODEM_CTL, 32'h01);
    pins(4'h4);
    $display("test modem control done");
    wr(usm_pkg::OFF_LINE_FMT, 32'h80);
    wr(usm_pkg::OFF_IRQ_EN, 32'hff);
    rd(usm_pkg::OFF_IRQ_EN, 32'h00);
    wr(usm_pkg::OFF_LINE_FMT, 32'h03);
    rd(usm_pkg::OFF_LINE_FMT, 32'h03);
    chk({24'h0, line_format}, 32'h03);
    wr(usm_pkg::OFF_IRQ_EN, 32'hff);
    rd(usm_pkg::OFF_IRQ_EN, 32'h0f);
    wait_irq(1'b1);
    rd(usm_pkg::OFF_IRQ_ID, 32'h02);
    wait_irq(1'b0);
    wr(usm_pkg::OFF_DATA, 32'ha5);
    #1;
    chk({23'h0, tx_data_valid, tx_data}, 32'h1a5);
    rd(usm_pkg::OFF_LINE_STS, 32'h00);
    usm_peer_inst.shift(1'b0, 1'b1);
    rd(usm_pkg::OFF_LINE_STS, 32'h20);
    wait_irq(1'b1);
    wr(usm_pkg::OFF_DATA, 32'h5a);
    wait_irq(1'b0);
    usm_peer_inst.shift(1'b0, 1'b1);
    usm_peer_inst.shift(1'b1, 1'b0);
    rd(usm_pkg::OFF_LINE_STS, 32'h60);
    rd(usm_pkg::OFF_IRQ_ID, 32'h02);
    $display("test transmit done");
    usm_peer_inst.rx(8'h3c, 1'b1, 1'b0, 1'b0);
    wait_irq(1'b1);
    rd(usm_pkg::OFF_IRQ_ID, 32'h06);
    rd(usm_pkg::OFF_LINE_STS, 32'h65);
    rd(usm_pkg::OFF_IRQ_ID, 32'h04);
    rd(usm_pkg::OFF_DATA, 32'h3c);
    rd(usm_pkg::OFF_LINE_STS, 32'h60);
    rd(usm_pkg::OFF_IRQ_ID, 32'h01);
    usm_peer_inst.rx(8'h11, 1'b0, 1'b0, 1'b0);
    usm_peer_inst.rx(8'h22, 1'b0, 1'b1, 1'b1);
    rd(usm_pkg::OFF_LINE_STS, 32'h7b);
    rd(usm_pkg::OFF_LINE_STS, 32'h61);
    rd(usm_pkg::OFF_DATA, 32'h22);
    wait_irq(1'b0);
    $display("test receive done");
    usm_peer_inst.cts(1'b0);
    wait_irq(1'b1);
    rd(usm_pkg::OFF_MODEM_STS, 32'h11);
    rd(usm_pkg::OFF_IRQ_ID, 32'h00);
    rd(usm_pkg::OFF_MODEM_STS, 32'h10);
    usm_peer_inst.cts(1'b1);
    rd(usm_pkg::OFF_MODEM_STS, 32'h01);
    rd(usm_pkg::OFF_MODEM_STS, 32'h00);
    rd(usm_pkg::OFF_IRQ_ID, 32'h01);
    wait_irq(1'b0);
    $display("test modem status done");
    pce <= 1'b0;
    usm_peer_inst.rx(8'h44, 1'b1, 1'b1, 1'b1);
    pce <= 1'b1;
    rd(usm_pkg::OFF_LINE_STS, 32'h60);
    rd(usm_pkg::OFF_DATA, 32'h22);
    rd(usm_pkg::OFF_IRQ_ID, 32'h01);
    $display("test clock enable done");
    apb(1'b1, 32'hffff0720, 32'hff, d, e);
    chk({31'h0, e}, 32'h1);
    wr(usm_pkg::OFF_LINE_STS, 32'h00);
    rd(usm_pkg::OFF_LINE_STS, 32'h60);
    $display("test refusals done");
    end_sim();
  end
endmodule
